// [ocm_output_compare.v]
`timescale 1ns/10ps
`include "ocm_defines.vh"
// Operation
// - Select bit set: secondary match or software clears
// - Select bit clear: only software clears flag
// - Mode 111: high on primary, low secondary
// - Mode 110: high at zero, low primary
// - Mode 101: start low, alternate toggles continuously
// - Mode 100: start low, one pulse
// - Mode 011: toggle on every primary match
// - Mode 010: start high, primary forces low
// - Mode 001: start low, primary forces high
// - Mode 000: channel disabled, pin held low; secondary match still clears flag when select bit set
// - Compare values double-buffered in PWM only
// - One trigger source per channel, outputs 4-7

module ocm_output_compare #(
  parameter CHANNEL_NUM = 1
) (
  // Clock and reset
  input wire SYS_CLK_I,
  input wire NRST_I,
  // Register port
  input wire [`OCM_ADDR_W-1:0] ADDR_I,
  input wire [`OCM_DATA_W-1:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output wire [`OCM_DATA_W-1:0] RDATA_O,
  // Timebase and trigger generator outputs four to seven
  input wire [`OCM_DATA_W-1:0] CHANNEL_TIMER_COUNT_I,
  input wire [3:0] TRIG_GEN_OUT_I,
  // Channel outputs
  output wire COMPARE_OUTPUT_PIN_O,
  output wire TRIGGER_STATUS_FLAG_O
);

  // ============================================================
  // Sequence states for the single-shot and double-compare modes
  localparam [1:0] SEQ_ARMED = 2'b00;
  localparam [1:0] SEQ_FIRST = 2'b01;
  localparam [1:0] SEQ_DONE = 2'b10;

  // ============================================================
  // PWM mode decoding used by the compare value buffering
  function is_pwm;
    input [2:0] mode;
    begin
      is_pwm = (mode == `OCM_MODE_PWM_EDGE) || (mode == `OCM_MODE_PWM_CENTER);
    end
  endfunction

  // ============================================================
  // Declarations
  reg [2:0] compare_mode_field_r;
  reg trig_flag_clear_select_r;
  reg timer_src_sel_r;
  reg trigger_status_flag_r;
  reg trigger_status_flag_nxt;
  reg [`OCM_DATA_W-1:0] pri_buf_r;
  reg [`OCM_DATA_W-1:0] sec_buf_r;
  reg [`OCM_DATA_W-1:0] primary_compare_value_r;
  reg [`OCM_DATA_W-1:0] secondary_compare_value_r;
  reg [`OCM_DATA_W-1:0] trig_count_r;
  reg out_r;
  reg out_nxt;
  reg [1:0] seq_r;
  reg [1:0] seq_nxt;
  reg [`OCM_DATA_W-1:0] rdata_r;
  reg [`OCM_DATA_W-1:0] rdata_nxt;
  wire wr_con1;
  wire wr_con2;
  wire wr_pri;
  wire wr_sec;
  wire [2:0] new_mode;
  wire pwm_now;
  wire trig_evt;
  wire [`OCM_DATA_W-1:0] count;
  wire pri_hit;
  wire sec_hit;
  wire zero_hit;
  wire flag_set;
  wire flag_clr;

  // ============================================================
  // Register write decode
  assign wr_con1 = WR_I && (ADDR_I == `OCM_OFF_CON1);
  assign wr_con2 = WR_I && (ADDR_I == `OCM_OFF_CON2);
  assign wr_pri = WR_I && (ADDR_I == `OCM_OFF_PRI);
  assign wr_sec = WR_I && (ADDR_I == `OCM_OFF_SEC);
  assign new_mode = WDATA_I[`OCM_CON1_MODE_MSB:`OCM_CON1_MODE_LSB];
  assign pwm_now = is_pwm(compare_mode_field_r);

  // ============================================================
  // Trigger source: one generator output per channel
  assign trig_evt = TRIG_GEN_OUT_I[CHANNEL_NUM-1];

  // Trigger-clocked channel count, used when the source bit is set
  always @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      trig_count_r <= `OCM_RST_VALUE;
    end else if (trig_evt) begin
      trig_count_r <= trig_count_r + 16'h0001;
    end
  end

  assign count = timer_src_sel_r ? trig_count_r : CHANNEL_TIMER_COUNT_I;

  // ============================================================
  // Comparators against the active compare values
  ocm_match #(
    .W(`OCM_DATA_W)
  ) u_match (
    .clk_i(SYS_CLK_I),
    .nrst_i(NRST_I),
    .count_i(count),
    .pri_i(primary_compare_value_r),
    .sec_i(secondary_compare_value_r),
    .pri_hit_o(pri_hit),
    .sec_hit_o(sec_hit),
    .zero_hit_o(zero_hit)
  );

  // ============================================================
  // Control registers
  always @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      compare_mode_field_r <= `OCM_RST_MODE;
      trig_flag_clear_select_r <= 1'b0;
      timer_src_sel_r <= 1'b0;
    end else begin
      if (wr_con1) begin
        compare_mode_field_r <= new_mode;
        trig_flag_clear_select_r <= WDATA_I[`OCM_CON1_CLRSEL_BIT];
      end
      if (wr_con2) begin
        timer_src_sel_r <= WDATA_I[`OCM_CON2_TSRC_BIT];
      end
    end
  end

  // ============================================================
  // Compare values: buffered in PWM, direct otherwise
  always @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      pri_buf_r <= `OCM_RST_VALUE;
      sec_buf_r <= `OCM_RST_VALUE;
      primary_compare_value_r <= `OCM_RST_VALUE;
      secondary_compare_value_r <= `OCM_RST_VALUE;
    end else begin
      if (wr_pri) begin
        pri_buf_r <= WDATA_I;
      end
      if (wr_sec) begin
        sec_buf_r <= WDATA_I;
      end
      if (pwm_now) begin
        // Period start loads both buffers together
        if (zero_hit) begin
          primary_compare_value_r <= pri_buf_r;
          secondary_compare_value_r <= sec_buf_r;
        end
      end else begin
        if (wr_pri) begin
          primary_compare_value_r <= WDATA_I;
        end
        if (wr_sec) begin
          secondary_compare_value_r <= WDATA_I;
        end
      end
    end
  end

  // ============================================================
  // Trigger status flag: a set in the same cycle wins over a clear
  assign flag_set = trig_evt || (wr_con2 && WDATA_I[`OCM_CON2_FLAG_BIT]);
  assign flag_clr = (wr_con2 && !WDATA_I[`OCM_CON2_FLAG_BIT])
                    || (trig_flag_clear_select_r && sec_hit);

  always @* begin
    trigger_status_flag_nxt = trigger_status_flag_r;
    if (flag_set) begin
      trigger_status_flag_nxt = 1'b1;
    end else if (flag_clr) begin
      trigger_status_flag_nxt = 1'b0;
    end
  end

  // ============================================================
  // Output pin sequencing
  always @* begin
    out_nxt = out_r;
    seq_nxt = seq_r;
    if (wr_con1) begin
      // Mode write re-arms the sequence and initialises the pin, except toggle mode which holds it
      seq_nxt = SEQ_ARMED;
      case (new_mode)
        `OCM_MODE_SS_LOW: begin
          out_nxt = 1'b1;
        end
        `OCM_MODE_TOGGLE: begin
          out_nxt = out_r;
        end
        default: begin
          out_nxt = 1'b0;
        end
      endcase
    end else begin
      case (compare_mode_field_r)
        `OCM_MODE_OFF: begin
          out_nxt = 1'b0;
        end
        `OCM_MODE_SS_HIGH: begin
          if ((seq_r == SEQ_ARMED) && pri_hit) begin
            out_nxt = 1'b1;
            seq_nxt = SEQ_DONE;
          end
        end
        `OCM_MODE_SS_LOW: begin
          if ((seq_r == SEQ_ARMED) && pri_hit) begin
            out_nxt = 1'b0;
            seq_nxt = SEQ_DONE;
          end
        end
        `OCM_MODE_TOGGLE: begin
          if (pri_hit) begin
            out_nxt = !out_r;
          end
        end
        `OCM_MODE_DC_SINGLE: begin
          if ((seq_r == SEQ_ARMED) && pri_hit) begin
            out_nxt = !out_r;
            seq_nxt = SEQ_FIRST;
          end else if ((seq_r == SEQ_FIRST) && sec_hit) begin
            out_nxt = !out_r;
            seq_nxt = SEQ_DONE;
          end
        end
        `OCM_MODE_DC_CONT: begin
          if ((seq_r == SEQ_ARMED) && pri_hit) begin
            out_nxt = !out_r;
            seq_nxt = SEQ_FIRST;
          end else if ((seq_r == SEQ_FIRST) && sec_hit) begin
            out_nxt = !out_r;
            seq_nxt = SEQ_ARMED;
          end
        end
        `OCM_MODE_PWM_EDGE: begin
          // A match on zero duty keeps the pin low
          if (pri_hit) begin
            out_nxt = 1'b0;
          end else if (zero_hit) begin
            out_nxt = 1'b1;
          end
        end
        `OCM_MODE_PWM_CENTER: begin
          if (sec_hit) begin
            out_nxt = 1'b0;
          end else if (pri_hit) begin
            out_nxt = 1'b1;
          end
        end
        default: begin
          out_nxt = out_r;
        end
      endcase
    end
  end

  // ============================================================
  // Output and flag state
  always @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      out_r <= `OCM_RST_PIN;
      seq_r <= SEQ_ARMED;
      trigger_status_flag_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      seq_r <= seq_nxt;
      trigger_status_flag_r <= trigger_status_flag_nxt;
    end
  end

  // ============================================================
  // Read mux; unmapped indexes read zero
  always @* begin
    rdata_nxt = {`OCM_DATA_W{1'b0}};
    if (RD_I) begin
      case (ADDR_I)
        `OCM_OFF_CON1: begin
          rdata_nxt[`OCM_CON1_MODE_MSB:`OCM_CON1_MODE_LSB] = compare_mode_field_r;
          rdata_nxt[`OCM_CON1_CLRSEL_BIT] = trig_flag_clear_select_r;
        end
        `OCM_OFF_CON2: begin
          rdata_nxt[`OCM_CON2_FLAG_BIT] = trigger_status_flag_r;
          rdata_nxt[`OCM_CON2_TSRC_BIT] = timer_src_sel_r;
        end
        `OCM_OFF_PRI: begin
          rdata_nxt = pri_buf_r;
        end
        `OCM_OFF_SEC: begin
          rdata_nxt = sec_buf_r;
        end
        `OCM_OFF_STAT: begin
          rdata_nxt[`OCM_STAT_PIN_BIT] = out_r;
          rdata_nxt[`OCM_STAT_SEQ_MSB:`OCM_STAT_SEQ_LSB] = seq_r;
        end
        `OCM_OFF_CNT: begin
          rdata_nxt = count;
        end
        default: begin
          rdata_nxt = {`OCM_DATA_W{1'b0}};
        end
      endcase
    end
  end

  // Read data stands for one cycle after the strobe
  always @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      rdata_r <= {`OCM_DATA_W{1'b0}};
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ============================================================
  // Outputs straight from flip-flops
  assign RDATA_O = rdata_r;
  assign COMPARE_OUTPUT_PIN_O = out_r;
  assign TRIGGER_STATUS_FLAG_O = trigger_status_flag_r;

endmodule

// [ocm_defines.vh]
`ifndef OCM_DEFINES_VH
`define OCM_DEFINES_VH

// ============================================================
// Register port geometry
`define OCM_ADDR_W 3
`define OCM_DATA_W 16

// ============================================================
// Register indexes on the register port
`define OCM_OFF_CON1 3'h0
`define OCM_OFF_CON2 3'h1
`define OCM_OFF_PRI 3'h2
`define OCM_OFF_SEC 3'h3
`define OCM_OFF_STAT 3'h4
`define OCM_OFF_CNT 3'h5

// ============================================================
// Field positions in compare_channel_control_one
`define OCM_CON1_MODE_LSB 0
`define OCM_CON1_MODE_MSB 2
`define OCM_CON1_CLRSEL_BIT 3

// ============================================================
// Field positions in compare_channel_control_two
`define OCM_CON2_FLAG_BIT 6
`define OCM_CON2_TSRC_BIT 7

// ============================================================
// Field positions in the status register
`define OCM_STAT_PIN_BIT 0
`define OCM_STAT_SEQ_LSB 1
`define OCM_STAT_SEQ_MSB 2

// ============================================================
// Encodings of compare_mode_field
`define OCM_MODE_OFF 3'h0
`define OCM_MODE_SS_HIGH 3'h1
`define OCM_MODE_SS_LOW 3'h2
`define OCM_MODE_TOGGLE 3'h3
`define OCM_MODE_DC_SINGLE 3'h4
`define OCM_MODE_DC_CONT 3'h5
`define OCM_MODE_PWM_EDGE 3'h6
`define OCM_MODE_PWM_CENTER 3'h7

// ============================================================
// Reset values
`define OCM_RST_MODE 3'h0
`define OCM_RST_VALUE 16'h0000
`define OCM_RST_PIN 1'b0

`endif

// [ocm_match.v]
`timescale 1ns/10ps
`include "ocm_defines.vh"

module ocm_match #(
  parameter W = `OCM_DATA_W
) (
  // Clock and reset
  input wire clk_i,
  input wire nrst_i,
  // Count and compare values
  input wire [W-1:0] count_i,
  input wire [W-1:0] pri_i,
  input wire [W-1:0] sec_i,
  // Match events, one cycle each
  output wire pri_hit_o,
  output wire sec_hit_o,
  output wire zero_hit_o
);

  // ============================================================
  // Count change detection
  reg [W-1:0] prev_r;
  reg seen_r;
  wire fresh;
  wire [3*W-1:0] refs;
  wire [2:0] hits;

  // Previous count, so a count that stalls matches only once
  always @(posedge clk_i) begin
    if (!nrst_i) begin
      prev_r <= {W{1'b0}};
      seen_r <= 1'b0;
    end else begin
      prev_r <= count_i;
      seen_r <= 1'b1;
    end
  end

  assign fresh = !seen_r || (count_i != prev_r);
  assign refs = {{W{1'b0}}, sec_i, pri_i};

  // ============================================================
  // One comparator per reference value
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : cmp
      assign hits[g] = fresh && (count_i == refs[g*W +: W]);
    end
  endgenerate

  assign pri_hit_o = hits[0];
  assign sec_hit_o = hits[1];
  assign zero_hit_o = hits[2];

endmodule

// [ocm_output_compare_asserts.sv]
`timescale 1ns/10ps
// ==========================================
// Checker of pin, flag and read port
module ocm_output_compare_asserts #(
  parameter CHANNEL_NUM = 1
) (
  // Clock, reset, register port
  input wire SYS_CLK_I,
  input wire NRST_I,
  input wire [2:0] ADDR_I,
  input wire [15:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [15:0] RDATA_O,
  // Timebase, triggers, outputs
  input wire [15:0] CHANNEL_TIMER_COUNT_I,
  input wire [3:0] TRIG_GEN_OUT_I,
  input wire COMPARE_OUTPUT_PIN_O,
  input wire TRIGGER_STATUS_FLAG_O
);
  reg [3:0] con_r;
  reg [15:0] pv_r, sv_r, pc_r;
  reg pok_r, sok_r, frst_r, tsrc_r;
  wire pin = COMPARE_OUTPUT_PIN_O;
  wire flg = TRIGGER_STATUS_FLAG_O;
  wire [15:0] ct = CHANNEL_TIMER_COUNT_I;
  wire tr = TRIG_GEN_OUT_I[CHANNEL_NUM-1];
  wire [2:0] md = con_r[2:0];
  // Shadow of mode and values; a value written in PWM is not trusted
  always @(posedge SYS_CLK_I) begin
    frst_r <= !NRST_I;
    pc_r <= ct;
    if (!NRST_I) begin
      con_r <= 4'h0;
      pv_r <= 16'h0000;
      sv_r <= 16'h0000;
      pok_r <= 1'b1;
      sok_r <= 1'b1;
      tsrc_r <= 1'b0;
    end else if (WR_I) begin
      if (ADDR_I == 3'h0) con_r <= WDATA_I[3:0];
      if (ADDR_I == 3'h2) pv_r <= WDATA_I;
      if (ADDR_I == 3'h2) pok_r <= md[2:1] != 2'b11;
      if (ADDR_I == 3'h3) sv_r <= WDATA_I;
      if (ADDR_I == 3'h3) sok_r <= md[2:1] != 2'b11;
      if (ADDR_I == 3'h1) tsrc_r <= WDATA_I[7];
    end
  end
  // Matches on a fresh timebase count with no write in the same cycle
  // The trigger-clocked internal count is not modelled, so no match is predicted then
  wire fresh = frst_r || ct != pc_r;
  wire hp = fresh && pok_r && !tsrc_r && !WR_I && ct == pv_r;
  wire hs = fresh && sok_r && !tsrc_r && !WR_I && ct == sv_r;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  // ==========================================
  // Assertions
  a_mode_off_low: assert property (md == 3'h0 && !WR_I |=> !pin)
    else $error("pin high while disabled");
  a_single_high: assert property (md == 3'h1 && hp |=> pin)
    else $error("pin not forced high");
  a_single_low: assert property (md == 3'h2 && hp |=> !pin)
    else $error("pin not forced low");
  a_toggle_pin: assert property (md == 3'h3 && hp |=> pin != $past(pin))
    else $error("pin did not toggle");
  a_flag_hw_clear: assert property (con_r[3] && md != 3'h0 && hs && !tr |=> !flg)
    else $error("flag not cleared by match");
  a_flag_sticky: assert property (!con_r[3] && flg && !WR_I |=> flg)
    else $error("flag cleared without software");
  a_trigger_sets: assert property (tr |=> flg)
    else $error("trigger did not set flag");
  a_read_idle: assert property (!RD_I |=> RDATA_O == 16'h0000)
    else $error("read data outside read slot");
  c_center: cover property (md == 3'h7 && $rose(pin));
  c_train: cover property (md == 3'h5 && $fell(pin));
  c_hw_clear: cover property (con_r[3] && $fell(flg));
endmodule

// [ocm_pin_load.sv]
`timescale 1ns/10ps
// ==========================================
// Load on the compare pin: tallies rises and high cycles
module ocm_pin_load (
  // Clock and tally clear
  input wire clk_i,
  input wire clr_i,
  // Pin and tallies
  input wire pin_i,
  output reg [31:0] rises_o,
  output reg [31:0] highs_o
);
  reg last_r;
  // Sample the pin on every rising edge
  always @(posedge clk_i) begin
    last_r <= pin_i;
    if (clr_i) begin
      rises_o <= 32'h0;
      highs_o <= 32'h0;
    end else begin
      rises_o <= rises_o + {31'h0, pin_i && !last_r};
      highs_o <= highs_o + {31'h0, pin_i};
    end
  end
endmodule

// [ocm_output_compare_tb_top.sv]
`timescale 1ns/10ps
module ocm_output_compare_tb_top;
  reg clk, nrst, wr, rd, clr;
  reg [2:0] addr;
  reg [15:0] wdata, cnt;
  reg [3:0] trig;
  wire [15:0] rdata;
  wire [31:0] rises, highs;
  wire pin, flag;
  integer mismatches, n_checks, i;
  // Per mode: mode, sweeps, rises, high cycles (-1 skip), final pin
  int tab [8][5] = '{'{1, 1, 1, -1, 1},
    '{0, 1, 0, 0, 0},
    '{2, 1, 0, -1, 0},
    '{3, 2, 1, 16, 0},
    '{4, 2, 1, 4, 0},
    '{5, 2, 2, 8, 0},
    '{6, 2, 2, 10, 0},
    '{7, 2, 2, 8, 0}};
  ocm_output_compare uut (.SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CHANNEL_TIMER_COUNT_I(cnt), .TRIG_GEN_OUT_I(trig),
    .COMPARE_OUTPUT_PIN_O(pin), .TRIGGER_STATUS_FLAG_O(flag));
  ocm_pin_load load (.clk_i(clk), .clr_i(clr), .pin_i(pin), .rises_o(rises), .highs_o(highs));
  // ==========================================
  // Compare and bus tasks
  task cmp16(input [15:0] e, input [15:0] g, input string n);
    n_checks = n_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("wrong value %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task cmp1(input e, input g, input string n);
    cmp16({15'h0, e}, {15'h0, g}, n);
  endtask
  task wr_reg(input [2:0] a, input [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_chk(input [2:0] a, input [15:0] e, input string n);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp16(e, rdata, n);
  endtask
  task ramp(input integer lo, input integer hi);
    integer j;
    for (j = lo; j <= hi; j = j + 1) begin
      @(posedge clk);
      cnt <= j[15:0];
    end
  endtask
  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task trig_chk(input [3:0] t, input e);
    @(posedge clk);
    trig <= t;
    @(posedge clk);
    trig <= 4'h0;
    settle;
    cmp1(e, flag, "flag after trigger");
  endtask
  task finish_test;
    if (mismatches == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    mismatches = mismatches + 1;
    finish_test;
  end
  // ==========================================
  // Main sequence
  initial begin
    {nrst, wr, rd, clr, addr, wdata, cnt, trig} = 0;
    mismatches = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_chk(3'h0, 16'h0000, "control one");
    wr_reg(3'h2, 16'h0005);
    wr_reg(3'h3, 16'h0009);
    for (i = 0; i < 8; i = i + 1) begin
      wr_reg(3'h0, 16'(tab[i][0]));
      settle;
      cmp1(tab[i][0] == 2, pin, "pin after mode write");
      @(posedge clk) clr <= 1'b1;
      @(posedge clk) clr <= 1'b0;
      repeat (tab[i][1]) ramp(0, 15);
      settle;
      cmp1(tab[i][4] == 1, pin, "final pin");
      cmp16(16'(tab[i][2]), rises[15:0], "rising edges");
      if (tab[i][3] >= 0) cmp16(16'(tab[i][3]), highs[15:0], "high cycles");
    end
    // PWM value written mid-period waits for the next period
    wr_reg(3'h0, 16'h0006);
    @(posedge clk) clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    ramp(0, 3);
    wr_reg(3'h2, 16'h0002);
    ramp(4, 15);
    ramp(0, 15);
    settle;
    cmp16(16'h0009, highs[15:0], "buffered high cycles");
    // Outside PWM a value written mid-period applies at once
    wr_reg(3'h0, 16'h0001);
    wr_reg(3'h2, 16'h0009);
    ramp(0, 3);
    wr_reg(3'h2, 16'h0002);
    ramp(4, 15);
    settle;
    cmp1(1'b0, pin, "pin with direct value");
    rd_chk(3'h2, 16'h0002, "primary value");
    wr_reg(3'h6, 16'hFFFF);
    rd_chk(3'h6, 16'h0000, "unmapped index");
    // Flag clearing with and without the select bit
    wr_reg(3'h0, 16'h000B);
    wr_reg(3'h1, 16'h0040);
    ramp(0, 15);
    settle;
    cmp1(1'b0, flag, "flag after match");
    wr_reg(3'h0, 16'h0003);
    wr_reg(3'h1, 16'h0040);
    ramp(0, 15);
    settle;
    cmp1(1'b1, flag, "flag kept");
    wr_reg(3'h1, 16'h0000);
    settle;
    cmp1(1'b0, flag, "flag after clear");
    trig_chk(4'h2, 1'b0);
    trig_chk(4'h1, 1'b1);
    // Trigger-clocked count as the compare source
    wr_reg(3'h1, 16'h00C0);
    rd_chk(3'h1, 16'h00C0, "control two");
    rd_chk(3'h5, 16'h0001, "trigger count");
    trig_chk(4'h1, 1'b1);
    rd_chk(3'h4, 16'h0001, "status after count match");
    cmp1(1'b1, pin, "pin on trigger count");
    finish_test;
  end
endmodule

bind ocm_output_compare ocm_output_compare_asserts #(.CHANNEL_NUM(CHANNEL_NUM)) chk (
  .SYS_CLK_I(SYS_CLK_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .CHANNEL_TIMER_COUNT_I(CHANNEL_TIMER_COUNT_I),
  .TRIG_GEN_OUT_I(TRIG_GEN_OUT_I), .COMPARE_OUTPUT_PIN_O(COMPARE_OUTPUT_PIN_O),
  .TRIGGER_STATUS_FLAG_O(TRIGGER_STATUS_FLAG_O));
